/* File: rtl/pdscb_top.sv */
// Pad and static debug configuration bank with Avalon-MM slave port
// Function
// - Per-pin slew select, 1 slow, resets zero
// - Per-pin receiver select, 1 Schmitt, resets ones
// - Bit 8 bypasses secure passive enable selector
// - Bit 7 bypasses secure active enable selector
// - Bit 6 bypasses passive enable selector
// - Bit 5 bypasses active enable selector
// - Bits 4:1 drop channel-out handshake
// - Bit 0 drops channel input/ack resync
// - Trigger outputs masked while active enable low, except where bits 27:24 are set
// - Trigger inputs masked while passive enable low, except where bits 23:16 are set
// - Bits 15:12 drop trigger-out handshake
// - Bits 11:8 drop trigger-ack synchronisation
// - Bits 7:0 drop trigger-input synchronisation
// - Read-only 32-bit identity word
// - Read-only loop lock flag, bit 2
// - Main clock ready flag bit 0, bit 1 reserved
`default_nettype none
module pdscb_top #(
  parameter logic [31:0] PART_ID = 32'h0000_5A01 // Arbitrary identity value
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [pdscb_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pdscb_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [pdscb_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Pad controls
  output logic [pdscb_pkg::PIN_N-1:0] pad_slew_select,
  output logic [pdscb_pkg::PIN_N-1:0] pad_input_receiver_select,
  // Debug enable pins and selector permission
  input wire logic secure_passive_debug_enable_pin,
  input wire logic secure_active_debug_enable_pin,
  input wire logic passive_debug_enable_pin,
  input wire logic active_debug_enable_pin,
  input wire logic [3:0] debug_selector_allow,
  // Resolved debug enables
  output logic secure_passive_debug_enable,
  output logic secure_active_debug_enable,
  output logic passive_debug_enable,
  output logic active_debug_enable,
  // Clock status sources
  input wire logic pll_locked,
  input wire logic main_clk_ready,
  // Cross-trigger channel interface
  input wire logic [pdscb_pkg::CH_N-1:0] trigger_channel_in,
  output logic [pdscb_pkg::CH_N-1:0] trigger_channel_in_sync,
  input wire logic [pdscb_pkg::CH_N-1:0] trigger_channel_out_req,
  input wire logic [pdscb_pkg::CH_N-1:0] trigger_channel_out_ack,
  output logic [pdscb_pkg::CH_N-1:0] trigger_channel_out,
  // Trigger interface
  input wire logic [pdscb_pkg::TIN_N-1:0] trigger_in,
  output logic [pdscb_pkg::TIN_N-1:0] trigger_in_gated,
  input wire logic [pdscb_pkg::TOUT_N-1:0] trigger_out_req,
  input wire logic [pdscb_pkg::TOUT_N-1:0] trigger_out_ack,
  output logic [pdscb_pkg::TOUT_N-1:0] trigger_out
);
  import pdscb_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pdscb_bus_e st_q, st_d;
  logic wait_q, wait_d, wr_fire;
  logic [31:0] rdata_q, rdata_d, rd_mux;
  logic [15:0] slew_q, slew_d, insel_q, insel_d;
  logic [8:0] auth_q, auth_d;
  logic [27:0] trig_q, trig_d;
  logic [2:0] clk_q, clk_d;
  logic [31:0] m_slew, m_insel, m_auth, m_trig;
  logic [3:0] en_q, en_d;
  logic [CH_N-1:0] ch_in_s, ch_ack_s, ch_out_h, ch_in_q, ch_in_d, ch_out_q, ch_out_d;
  logic [TIN_N-1:0] tin_s, tin_q, tin_d;
  logic [TOUT_N-1:0] tack_s, tout_h, tout_q, tout_d;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Write commits on the edge where the master sees waitrequest low
  assign wr_fire = avs_write && (st_q == BUS_ACK);

  // Read mux; reserved bits and unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      OFS_SLEW: rd_mux[15:0] = slew_q;
      OFS_INSEL: rd_mux[15:0] = insel_q;
      OFS_AUTH: rd_mux[8:0] = auth_q;
      OFS_TRIG: rd_mux[27:0] = trig_q;
      OFS_ID: rd_mux = PART_ID;
      OFS_CLK: rd_mux[2:0] = clk_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One-cycle answer: waitrequest drops for exactly one cycle
  always_comb begin
    st_d = st_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    unique case (st_q)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          st_d = BUS_ACK;
          wait_d = 1'b0;
          if (avs_read) begin
            rdata_d = rd_mux;
          end
        end
      end
      BUS_ACK: begin
        st_d = BUS_IDLE;
      end
      default: begin
        st_d = BUS_IDLE;
      end
    endcase
  end

  // Bus state registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  assign m_slew = wr_merge({16'h0000, slew_q}, avs_writedata, avs_byteenable);
  assign m_insel = wr_merge({16'h0000, insel_q}, avs_writedata, avs_byteenable);
  assign m_auth = wr_merge({23'h000000, auth_q}, avs_writedata, avs_byteenable);
  assign m_trig = wr_merge({4'h0, trig_q}, avs_writedata, avs_byteenable);

  // Only implemented widths are kept, so reserved bits drop writes
  always_comb begin
    slew_d = slew_q;
    insel_d = insel_q;
    auth_d = auth_q;
    trig_d = trig_q;
    if (wr_fire) begin
      case (avs_address)
        OFS_SLEW: slew_d = m_slew[15:0];
        OFS_INSEL: insel_d = m_insel[15:0];
        OFS_AUTH: auth_d = m_auth[8:0];
        OFS_TRIG: trig_d = m_trig[27:0];
        default: slew_d = slew_q;
      endcase
    end
  end

  // Register file; clock flags follow their sources every cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      slew_q <= RST_SLEW;
      insel_q <= RST_INSEL;
      auth_q <= RST_AUTH;
      trig_q <= RST_TRIG;
      clk_q <= RST_CLK;
    end else begin
      slew_q <= slew_d;
      insel_q <= insel_d;
      auth_q <= auth_d;
      trig_q <= trig_d;
      clk_q <= clk_d;
    end
  end

  always_comb begin
    clk_d = 3'h0;
    clk_d[CLK_PLL_BIT] = pll_locked;
    clk_d[CLK_MAIN_BIT] = main_clk_ready;
  end

  assign pad_slew_select = slew_q;
  assign pad_input_receiver_select = insel_q;

  // ----------------------------------------------------------------
  // Debug enable selectors
  // ----------------------------------------------------------------
  // Selector gates the pin with its permission; bypass takes the pin alone
  always_comb begin
    en_d[3] = auth_q[AUTH_SP_BIT] ? secure_passive_debug_enable_pin
                                  : secure_passive_debug_enable_pin & debug_selector_allow[3];
    en_d[2] = auth_q[AUTH_SA_BIT] ? secure_active_debug_enable_pin
                                  : secure_active_debug_enable_pin & debug_selector_allow[2];
    en_d[1] = auth_q[AUTH_P_BIT] ? passive_debug_enable_pin
                                 : passive_debug_enable_pin & debug_selector_allow[1];
    en_d[0] = auth_q[AUTH_A_BIT] ? active_debug_enable_pin
                                 : active_debug_enable_pin & debug_selector_allow[0];
  end

  // ----------------------------------------------------------------
  // Cross-trigger synchronisers and handshakes
  // ----------------------------------------------------------------
  // channel input resync
  pdscb_sync #(.W(CH_N)) u_ch_in (
    .core_clk(core_clk), .rst(rst),
    .sig_in(trigger_channel_in),
    .bypass({CH_N{auth_q[CH_IN_BIT]}}),
    .sig_out(ch_in_s)
  );

  pdscb_sync #(.W(CH_N)) u_ch_ack (
    .core_clk(core_clk), .rst(rst),
    .sig_in(trigger_channel_out_ack),
    .bypass({CH_N{auth_q[CH_IN_BIT]}}),
    .sig_out(ch_ack_s)
  );

  pdscb_hshk #(.W(CH_N)) u_ch_out (
    .core_clk(core_clk), .rst(rst),
    .req(trigger_channel_out_req),
    .ack(ch_ack_s),
    .bypass(auth_q[CH_OUT_LSB +: CH_N]),
    .held(ch_out_h)
  );

  pdscb_sync #(.W(TIN_N)) u_tin (
    .core_clk(core_clk), .rst(rst),
    .sig_in(trigger_in),
    .bypass(trig_q[TIN_SYNC_LSB +: TIN_N]),
    .sig_out(tin_s)
  );

  pdscb_sync #(.W(TOUT_N)) u_tack (
    .core_clk(core_clk), .rst(rst),
    .sig_in(trigger_out_ack),
    .bypass(trig_q[TACK_SYNC_LSB +: TOUT_N]),
    .sig_out(tack_s)
  );

  pdscb_hshk #(.W(TOUT_N)) u_tout (
    .core_clk(core_clk), .rst(rst),
    .req(trigger_out_req),
    .ack(tack_s),
    .bypass(trig_q[TOUT_HS_LSB +: TOUT_N]),
    .held(tout_h)
  );

  // Gating uses the registered enables to keep outputs glitch free
  always_comb begin
    ch_in_d = ch_in_s;
    ch_out_d = ch_out_h;
    tin_d = tin_s & (trig_q[TIN_GATE_LSB +: TIN_N] | {TIN_N{en_q[1]}});
    tout_d = tout_h & (trig_q[TOUT_GATE_LSB +: TOUT_N] | {TOUT_N{en_q[0]}});
  end

  // Output flops for enables and triggers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_q <= 4'h0;
      ch_in_q <= '0;
      ch_out_q <= '0;
      tin_q <= '0;
      tout_q <= '0;
    end else begin
      en_q <= en_d;
      ch_in_q <= ch_in_d;
      ch_out_q <= ch_out_d;
      tin_q <= tin_d;
      tout_q <= tout_d;
    end
  end

  assign secure_passive_debug_enable = en_q[3];
  assign secure_active_debug_enable = en_q[2];
  assign passive_debug_enable = en_q[1];
  assign active_debug_enable = en_q[0];
  assign trigger_channel_in_sync = ch_in_q;
  assign trigger_channel_out = ch_out_q;
  assign trigger_in_gated = tin_q;
  assign trigger_out = tout_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_slew_reset:
    assert property (@(posedge core_clk) $past(rst) && !rst |-> pad_slew_select == 16'h0000)
    else $error("slew select not zero after reset");
  a_insel_reset:
    assert property (@(posedge core_clk) $past(rst) && !rst |-> pad_input_receiver_select == 16'hFFFF)
    else $error("receiver select not all ones after reset");
  a_slew_write:
    assert property (@(posedge core_clk) disable iff (rst)
      wr_fire && avs_address == OFS_SLEW && avs_byteenable == 4'hF
      |=> pad_slew_select == $past(avs_writedata[15:0]))
    else $error("slew write not stored");
  a_sp_bypass:
    assert property (@(posedge core_clk) disable iff (rst)
      auth_q[8] |=> secure_passive_debug_enable == $past(secure_passive_debug_enable_pin))
    else $error("secure passive enable not taken from pin");
  a_sa_selector:
    assert property (@(posedge core_clk) disable iff (rst)
      !auth_q[7] |=> secure_active_debug_enable == $past(secure_active_debug_enable_pin & debug_selector_allow[2]))
    else $error("secure active selector not applied");
  a_p_bypass:
    assert property (@(posedge core_clk) disable iff (rst)
      auth_q[6] |=> passive_debug_enable == $past(passive_debug_enable_pin))
    else $error("passive enable not taken from pin");
  a_a_bypass:
    assert property (@(posedge core_clk) disable iff (rst)
      auth_q[5] |=> active_debug_enable == $past(active_debug_enable_pin))
    else $error("active enable not taken from pin");
  a_tout_mask:
    assert property (@(posedge core_clk) disable iff (rst)
      !active_debug_enable |=> (trigger_out & ~$past(trig_q[27:24])) == 4'h0)
    else $error("trigger output leaked while active enable low");
  a_tin_mask:
    assert property (@(posedge core_clk) disable iff (rst)
      !passive_debug_enable |=> (trigger_in_gated & ~$past(trig_q[23:16])) == 8'h00)
    else $error("trigger input leaked while passive enable low");
  a_tin_sync_delay:
    assert property (@(posedge core_clk) disable iff (rst)
      trig_q[7:0] == 8'h00 && trig_q[23:16] == 8'hFF ##1 trig_q[7:0] == 8'h00 && trig_q[23:16] == 8'hFF
      ##1 trig_q[7:0] == 8'h00 && trig_q[23:16] == 8'hFF |=> trigger_in_gated == $past(trigger_in, 3))
    else $error("trigger input not three cycles behind");
  a_id_read:
    assert property (@(posedge core_clk) disable iff (rst)
      st_q == BUS_IDLE && avs_read && avs_address == OFS_ID |=> !avs_waitrequest && avs_readdata == PART_ID)
    else $error("identity word wrong");
  a_clk_read:
    assert property (@(posedge core_clk) disable iff (rst)
      st_q == BUS_IDLE && avs_read && avs_address == OFS_CLK
      |=> avs_readdata[31:3] == 29'h0 && !avs_readdata[1] && avs_readdata[2] == $past(clk_q[2]))
    else $error("clock status readback wrong");
  a_bus_answer:
    assert property (@(posedge core_clk) disable iff (rst)
      st_q == BUS_IDLE && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not low for exactly one cycle");

endmodule : pdscb_top
`default_nettype wire

/* File: rtl/pdscb_pkg.sv */
// Package: offsets, fields and reset values of the pad and debug config bank
`default_nettype none
package pdscb_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register offsets
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_SLEW = 8'h00;
  localparam logic [7:0] OFS_INSEL = 8'h04;
  localparam logic [7:0] OFS_AUTH = 8'h08;
  localparam logic [7:0] OFS_TRIG = 8'h0C;
  localparam logic [7:0] OFS_ID = 8'h10;
  localparam logic [7:0] OFS_CLK = 8'h14;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int unsigned PIN_N = 16;
  localparam int unsigned CH_N = 4;
  localparam int unsigned TOUT_N = 4;
  localparam int unsigned TIN_N = 8;
  localparam int unsigned AUTH_SP_BIT = 8;
  localparam int unsigned AUTH_SA_BIT = 7;
  localparam int unsigned AUTH_P_BIT = 6;
  localparam int unsigned AUTH_A_BIT = 5;
  localparam int unsigned CH_OUT_LSB = 1;
  localparam int unsigned CH_IN_BIT = 0;
  localparam int unsigned TOUT_GATE_LSB = 24;
  localparam int unsigned TIN_GATE_LSB = 16;
  localparam int unsigned TOUT_HS_LSB = 12;
  localparam int unsigned TACK_SYNC_LSB = 8;
  localparam int unsigned TIN_SYNC_LSB = 0;
  localparam int unsigned CLK_PLL_BIT = 2;
  localparam int unsigned CLK_MAIN_BIT = 0;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SLEW = 16'h0000;
  localparam logic [15:0] RST_INSEL = 16'hFFFF;
  localparam logic [8:0] RST_AUTH = 9'h000;
  localparam logic [27:0] RST_TRIG = 28'h0000000;
  localparam logic [2:0] RST_CLK = 3'h5;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } pdscb_bus_e;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : wr_merge

endpackage : pdscb_pkg
`default_nettype wire

/* File: rtl/pdscb_sync.sv */
// Two-stage synchroniser bank with per-bit bypass for same-clock sources
`default_nettype none
module pdscb_sync #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Data in, bypass select, data out
  input wire logic [W-1:0] sig_in,
  input wire logic [W-1:0] bypass,
  output logic [W-1:0] sig_out
);
  import pdscb_pkg::*;

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] stable_q;
  logic [W-1:0] stable_d;

  // Next values of the two stages
  always_comb begin
    meta_d = sig_in;
    stable_d = meta_q;
  end

  // Stage registers; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= meta_d;
      stable_q <= stable_d;
    end
  end

  // Bypassed bits skip both stages and save two cycles of latency
  for (genvar i = 0; i < W; i++) begin : g_out
    assign sig_out[i] = bypass[i] ? sig_in[i] : stable_q[i];
  end

endmodule : pdscb_sync
`default_nettype wire

/* File: rtl/pdscb_hshk.sv */
// Request-hold handshake bank with per-bit bypass
`default_nettype none
module pdscb_hshk #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request, acknowledge, bypass select and held output
  input wire logic [W-1:0] req,
  input wire logic [W-1:0] ack,
  input wire logic [W-1:0] bypass,
  output logic [W-1:0] held
);
  import pdscb_pkg::*;

  logic [W-1:0] pend_q;
  logic [W-1:0] pend_d;

  // Hold until acknowledged; a new request beats a same-cycle ack
  always_comb begin
    pend_d = pend_q;
    for (int i = 0; i < W; i++) begin
      if (bypass[i]) begin
        pend_d[i] = 1'b0;
      end else begin
        pend_d[i] = req[i] | (pend_q[i] & ~ack[i]);
      end
    end
  end

  // Pending flags
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Bypassed bits follow the request directly
  for (genvar i = 0; i < W; i++) begin : g_out
    assign held[i] = bypass[i] ? req[i] : pend_q[i];
  end

endmodule : pdscb_hshk
`default_nettype wire

/* File: tb/pdscb_top_tb.sv */
// Self-checking bench for the pad and debug configuration bank
`default_nettype none
module pdscb_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pdscb_pkg::*;

  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  localparam logic [31:0] TB_ID = 32'h1234_0ABC; // Arbitrary identity value
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd_q;
  logic [3:0] avs_byteenable, en_pin, allow, en_out;
  logic [15:0] slew, insel;
  logic pll_locked, main_clk_ready;
  logic [3:0] ch_in, ch_in_sync, ch_req, ch_ack, ch_out, treq, tack, tout;
  logic [7:0] tin, tin_g;
  int mismatches = 0;
  int cmp_count = 0;

  pdscb_top #(.PART_ID(TB_ID)) uut (
    .core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pad_slew_select(slew), .pad_input_receiver_select(insel),
    .secure_passive_debug_enable_pin(en_pin[3]), .secure_active_debug_enable_pin(en_pin[2]),
    .passive_debug_enable_pin(en_pin[1]), .active_debug_enable_pin(en_pin[0]),
    .debug_selector_allow(allow),
    .secure_passive_debug_enable(en_out[3]), .secure_active_debug_enable(en_out[2]),
    .passive_debug_enable(en_out[1]), .active_debug_enable(en_out[0]),
    .pll_locked(pll_locked), .main_clk_ready(main_clk_ready),
    .trigger_channel_in(ch_in), .trigger_channel_in_sync(ch_in_sync),
    .trigger_channel_out_req(ch_req), .trigger_channel_out_ack(ch_ack), .trigger_channel_out(ch_out),
    .trigger_in(tin), .trigger_in_gated(tin_g),
    .trigger_out_req(treq), .trigger_out_ack(tack), .trigger_out(tout)
  );

  // Clock at 10 MHz
  always #50 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------------------------------
  // Value check, counted
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Write held until waitrequest is seen low
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr

  // Read, data taken at the answering edge, then compared
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    chk($sformatf("reg %h", a), exp, rd_q);
  endtask : chk_reg

  // Let n edges land, then look
  task automatic wait_look(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_look

  // Single place where the run ends
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    en_pin = 4'hF;
    allow = 4'h0;
    pll_locked = 1'b1;
    main_clk_ready = 1'b1;
    ch_in = 4'h0;
    ch_req = 4'h0;
    ch_ack = 4'h0;
    tin = 8'h00;
    treq = 4'h0;
    tack = 4'h0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    // Values after reset
    chk_reg(OFS_CLK, 32'h0000_0005);
    chk_reg(OFS_SLEW, 32'h0000_0000);
    chk_reg(OFS_INSEL, 32'h0000_FFFF);
    chk_reg(OFS_AUTH, 32'h0000_0000);
    chk_reg(OFS_TRIG, 32'h0000_0000);
    chk_reg(OFS_ID, TB_ID);
    chk("insel pins", 32'h0000_FFFF, {16'h0000, insel});
    // Reserved bits, byte lanes, read-only and unmapped places
    bus_wr(OFS_SLEW, 32'hFFFF_A5C3, 4'hF);
    chk_reg(OFS_SLEW, 32'h0000_A5C3);
    chk("slew pins", 32'h0000_A5C3, {16'h0000, slew});
    bus_wr(OFS_INSEL, 32'hFFFF_0000, 4'h1);
    chk_reg(OFS_INSEL, 32'h0000_FF00);
    chk("insel pins", 32'h0000_FF00, {16'h0000, insel});
    bus_wr(OFS_AUTH, 32'hFFFF_FFFF, 4'hF);
    chk_reg(OFS_AUTH, 32'h0000_01FF);
    bus_wr(OFS_TRIG, 32'hFFFF_FFFF, 4'hF);
    chk_reg(OFS_TRIG, 32'h0FFF_FFFF);
    bus_wr(OFS_ID, 32'h0000_0000, 4'hF);
    chk_reg(OFS_ID, TB_ID);
    bus_wr(OFS_CLK, 32'h0000_0000, 4'hF);
    chk_reg(OFS_CLK, 32'h0000_0005);
    bus_wr(8'h18, 32'hFFFF_FFFF, 4'hF);
    chk_reg(8'h18, 32'h0000_0000);
    // Clock flags follow their sources
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      pll_locked <= i[1];
      main_clk_ready <= i[0];
      chk_reg(OFS_CLK, {29'h0000_0000, i[1], 1'b0, i[0]});
    end
    // Selectors closed, each bypass bit opens one enable alone
    bus_wr(OFS_AUTH, 32'h0000_0000, 4'hF);
    wait_look(2);
    chk("enables", 32'h0000_0000, {28'h0000_000, en_out});
    for (int i = 0; i < 4; i++) begin
      bus_wr(OFS_AUTH, 32'h0000_0020 << i, 4'hF);
      wait_look(2);
      chk("enables", 32'h0000_0001 << i, {28'h0000_000, en_out});
    end
    // Selectors opened by permission, pins high
    @(posedge core_clk);
    allow <= 4'hF;
    bus_wr(OFS_AUTH, 32'h0000_0000, 4'hF);
    wait_look(2);
    chk("enables open", 32'h0000_000F, {28'h0000_000, en_out});
    @(posedge core_clk);
    en_pin <= 4'h0;
    // Trigger inputs: gate and bypassed sync, passive enable low
    bus_wr(OFS_TRIG, 32'h000F_00FF, 4'hF);
    @(posedge core_clk);
    tin <= 8'hFF;
    wait_look(1);
    chk("trig in", 32'h0000_000F, {24'h00_0000, tin_g});
    bus_wr(OFS_TRIG, 32'h00FF_0000, 4'hF);
    @(posedge core_clk);
    tin <= 8'h3C;
    wait_look(1);
    chk("trig in early", 32'h0000_00FF, {24'h00_0000, tin_g});
    wait_look(2);
    chk("trig in late", 32'h0000_003C, {24'h00_0000, tin_g});
    // Channel inputs, synchronised then bypassed
    @(posedge core_clk);
    ch_in <= 4'hA;
    wait_look(1);
    chk("chan in early", 32'h0000_0000, {28'h0000_000, ch_in_sync});
    wait_look(2);
    chk("chan in late", 32'h0000_000A, {28'h0000_000, ch_in_sync});
    bus_wr(OFS_AUTH, 32'h0000_0001, 4'hF);
    @(posedge core_clk);
    ch_in <= 4'h5;
    wait_look(1);
    chk("chan in bypass", 32'h0000_0005, {28'h0000_000, ch_in_sync});
    // Channel outputs: channels 0 and 2 bypassed, 1 and 3 held
    bus_wr(OFS_AUTH, 32'h0000_000A, 4'hF);
    @(posedge core_clk);
    ch_req <= 4'hF;
    @(posedge core_clk);
    ch_req <= 4'h0;
    wait_look(4);
    chk("chan out held", 32'h0000_000A, {28'h0000_000, ch_out});
    @(posedge core_clk);
    ch_ack <= 4'hF;
    wait_look(5);
    chk("chan out acked", 32'h0000_0000, {28'h0000_000, ch_out});
    // Trigger outputs: mask by gate with active enable low, handshake bypassed
    bus_wr(OFS_TRIG, 32'h0500_F000, 4'hF);
    @(posedge core_clk);
    treq <= 4'hF;
    wait_look(4);
    chk("trig out gated", 32'h0000_0005, {28'h0000_000, tout});
    @(posedge core_clk);
    treq <= 4'h0;
    wait_look(3);
    chk("trig out dropped", 32'h0000_0000, {28'h0000_000, tout});
    // Handshake kept, acknowledge sync bypassed
    bus_wr(OFS_TRIG, 32'h0F00_0F00, 4'hF);
    @(posedge core_clk);
    treq <= 4'hF;
    @(posedge core_clk);
    treq <= 4'h0;
    wait_look(4);
    chk("trig out held", 32'h0000_000F, {28'h0000_000, tout});
    @(posedge core_clk);
    tack <= 4'hF;
    wait_look(4);
    chk("trig out acked", 32'h0000_0000, {28'h0000_000, tout});
    wrap_up();
  end

endmodule : pdscb_top_tb
`default_nettype wire
